//--- rtl/afc_ctrl.sv
// frame decode, power mode and serial result shifter
// How it works
// RULE1: frame select falling puts the device in normal mode and starts conversion.
// RULE2: rise between second and tenth falling edge aborts, tri-states, enters shutdown.
// RULE3: rise before second falling edge leaves the power mode unchanged.
// RULE4: rise after tenth, before sixteenth edge aborts, tri-states, stays normal.
// RULE5: shutdown holds until frame select falls again.
// RULE6: power-down enable output is high throughout shutdown mode.
// RULE7: word takes sixteen clock cycles, then output goes high impedance.
// RULE8: host may idle select either level, raising it before next frame.
// RULE9: host waits the quiet interval before starting another conversion.
// RULE10: wake-up frame result is invalid; the following conversion is valid.
// RULE11: in a wake-up frame, early rise before tenth edge returns to shutdown.
// RULE12: select low past tenth edge of wake frame: normal, powered after sixteen.
// RULE13: host does one dummy conversion after power is applied.
// RULE14: host keeps the quiet interval after that dummy conversion too.
// RULE15: host keeps normal mode and twenty clock frames for full throughput.
// RULE16: host raises select between second and tenth edge to save power.
// RULE17: select falling samples the input and enables the result output.
// RULE18: three zeros, eight bits msb first, four zeros, shifted on falling edges.
// RULE19: output tri-states at sixteenth falling edge or select rise, first wins.
// RULE20: falling clock edges are counted from select fall to choose mode.
`timescale 1ns/100ps
module afc_ctrl
	import afc_pkg::*;
#(
	parameter int unsigned     DEPTH      = afc_pkg::FIFO_DEPTH,
	parameter afc_pkg::afc_mode_t INIT_MODE = afc_pkg::AFC_MODE_NORMAL
) (
	input  wire logic                      core_clk,
	input  wire logic                      arst_n,
	input  wire logic                      frame_sel_n,
	input  wire logic                      serial_clk,
	input  wire logic                      sample_valid,
	output logic                           sample_ready,
	input  wire logic [afc_pkg::DATA_W-1:0] sample_data,
	output logic                           serial_result_out,
	output logic                           serial_result_oe,
	output logic                           power_down_en,
	output logic                           normal_mode,
	output logic                           result_valid,
	output logic                           conv_active
);
	import afc_pkg::*;

	// =====================================================
	// reset release
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// =====================================================
	// pin synchronisers, bit 1 select, bit 0 clock
	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic [1:0] s3_q;
	logic [1:0] pin_q;
	logic [1:0] pin_d;
	logic       sel_fall;
	logic       sel_rise;
	logic       clk_fall;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q  <= PIN_IDLE;
			s2_q  <= PIN_IDLE;
			s3_q  <= PIN_IDLE;
			pin_q <= PIN_IDLE;
		end else begin
			s1_q  <= {frame_sel_n, serial_clk};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			pin_q <= pin_d;
		end
	end

	assign pin_d    = (pin_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
	assign sel_fall = pin_q[1] && !pin_d[1];
	assign sel_rise = !pin_q[1] && pin_d[1];
	assign clk_fall = pin_q[0] && !pin_d[0];

	// =====================================================
	// sample buffer
	logic              fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	logic              take;

	assign take = sel_fall;

	afc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (core_clk),
		.rst_n     (rst_n),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.in_data   (sample_data),
		.out_valid (fifo_valid),
		.out_ready (take),
		.out_data  (fifo_data)
	);

	// =====================================================
	// falling edge counter
	logic [CNT_W-1:0] fall_cnt_q;
	logic             frame_q;
	logic             last_fall;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fall_cnt_q <= '0;
			frame_q    <= 1'b0;
		end else if (sel_fall) begin
			fall_cnt_q <= FALL_ZERO;                    // [RULE20]
			frame_q    <= 1'b1;
		end else if (sel_rise) begin
			frame_q    <= 1'b0;
		end else if (frame_q && clk_fall) begin
			fall_cnt_q <= fall_cnt_q + FALL_ONE;        // [RULE20]
			if (fall_cnt_q + FALL_ONE == FALL_WORD) begin
				frame_q <= 1'b0;                    // [RULE7]
			end
		end
	end

	assign last_fall = frame_q && clk_fall &&
		(fall_cnt_q + FALL_ONE == FALL_WORD);

	// =====================================================
	// result shifter
	logic [SHIFT_W-1:0] shift_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q           <= '0;
			serial_result_out <= 1'b0;
			serial_result_oe  <= 1'b0;
		end else if (sel_fall) begin
			shift_q <= {{LEAD_ZEROS{1'b0}},
				fifo_valid ? fifo_data : {DATA_W{1'b0}},
				{TRAIL_ZEROS{1'b0}}};               // [RULE17] [RULE18]
			serial_result_out <= 1'b0;
			serial_result_oe  <= 1'b1;                  // [RULE17]
		end else if (sel_rise) begin
			serial_result_oe  <= 1'b0;       // [RULE2] [RULE4] [RULE19]
		end else if (frame_q && clk_fall) begin
			shift_q           <= {shift_q[SHIFT_W-2:0], 1'b0};
			serial_result_out <= shift_q[SHIFT_W-2];    // [RULE18]
			if (fall_cnt_q + FALL_ONE == FALL_WORD) begin
				serial_result_oe <= 1'b0;           // [RULE7] [RULE19]
			end
		end
	end

	// =====================================================
	// power mode
	afc_mode_t mode_q;
	afc_mode_t mode_at_fall_q;
	afc_mode_t rise_mode;
	logic      wake_pend_q;
	logic      wake_frame_q;

	// mode picked by the falls counted when select rises
	always_comb begin
		case (1'b1)
			(fall_cnt_q < FALL_SHDN_FIRST): begin
				rise_mode = mode_at_fall_q;   // [RULE3] [RULE11]
			end
			(fall_cnt_q <= FALL_SHDN_LAST): begin
				rise_mode = AFC_MODE_SHUTDOWN; // [RULE2] [RULE11]
			end
			default: begin
				rise_mode = AFC_MODE_NORMAL;  // [RULE4]
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q         <= INIT_MODE;
			mode_at_fall_q <= INIT_MODE;
			wake_pend_q    <= 1'b1;
			wake_frame_q   <= 1'b0;
		end else if (sel_fall) begin
			mode_q         <= AFC_MODE_NORMAL;              // [RULE1]
			mode_at_fall_q <= mode_q;
			wake_frame_q   <= wake_pend_q ||
				(mode_q == AFC_MODE_SHUTDOWN);          // [RULE10]
			if (mode_q == AFC_MODE_SHUTDOWN) begin
				wake_pend_q <= 1'b1;
			end
		end else if (sel_rise && frame_q) begin
			mode_q <= rise_mode;                  // [RULE2] [RULE3] [RULE4]
		end else if (last_fall) begin
			wake_pend_q <= 1'b0;                        // [RULE12]
		end
	end

	// =====================================================
	// status outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_down_en <= 1'b0;
			normal_mode   <= 1'b0;
			result_valid  <= 1'b0;
			conv_active   <= 1'b0;
		end else begin
			power_down_en <= (mode_q == AFC_MODE_SHUTDOWN); // [RULE5] [RULE6]
			normal_mode   <= (mode_q == AFC_MODE_NORMAL);
			result_valid  <= frame_q && !wake_frame_q;      // [RULE10]
			conv_active   <= frame_q;
		end
	end
endmodule // afc_ctrl

//--- rtl/afc_pkg.sv
// shared constants of the frame and power mode controller
package afc_pkg;
	// =====================================================
	// frame layout
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned LEAD_ZEROS  = 3;
	localparam int unsigned TRAIL_ZEROS = 4;
	localparam int unsigned SHIFT_W     = LEAD_ZEROS + DATA_W + TRAIL_ZEROS;
	localparam int unsigned CNT_W       = 5;
	// =====================================================
	// falling edge counts of the serial clock
	localparam logic [4:0] FALL_SHDN_FIRST = 5'h02;
	localparam logic [4:0] FALL_SHDN_LAST  = 5'h09;
	localparam logic [4:0] FALL_WORD       = 5'h10;
	localparam logic [4:0] FALL_ZERO       = 5'h00;
	localparam logic [4:0] FALL_ONE        = 5'h01;
	// =====================================================
	// pins and timing
	localparam int unsigned SYNC_STAGES  = 3;
	localparam logic [1:0]  PIN_IDLE     = 2'h3;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned FIFO_DEPTH   = 32;
	// =====================================================
	// power modes
	typedef enum logic {
		AFC_MODE_NORMAL   = 1'b0,
		AFC_MODE_SHUTDOWN = 1'b1
	} afc_mode_t;
endpackage

//--- rtl/afc_fifo.sv
// sample word fifo with valid and ready on both sides
`timescale 1ns/100ps
module afc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
	localparam logic [AW:0] CNT_ZERO = '0;
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_q != CNT_ZERO);
	assign out_data  = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q     <= '0;
			rd_q     <= '0;
			cnt_q    <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
			end
			cnt_q    <= cnt_d;
			in_ready <= (cnt_d != CNT_FULL);
		end
	end
endmodule // afc_fifo

//--- verif/afc_host.sv
// serial host model driving frame select and the serial clock
`timescale 1ns/100ps
module afc_host (
	input  wire logic core_clk,
	input  wire logic sdo,
	output logic      frame_sel_n,
	output logic      serial_clk
);
	logic [15:0] word;
	// =========
	// idle lines, clock stands still high
	initial begin
		frame_sel_n = 1'b1;
		serial_clk  = 1'b1;
		word        = 16'h0000;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// =========
	// one frame, select raised after the given count of falls
	task automatic frame(input int falls);
		frame_sel_n = 1'b0;
		wt(8);
		for (int i = 0; i < falls; i++) begin
			word = {word[14:0], sdo};
			serial_clk = 1'b0;
			wt(4);
			serial_clk = 1'b1;
			wt(4);
		end
		frame_sel_n = 1'b1;
		wt(24);
	endtask
endmodule // afc_host

//--- verif/afc_ctrl_asserts.sv
// port checker of the frame and power mode controller
`timescale 1ns/100ps
module afc_ctrl_asserts (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic frame_sel_n,
	input wire logic serial_clk,
	input wire logic serial_result_out,
	input wire logic serial_result_oe,
	input wire logic power_down_en,
	input wire logic normal_mode,
	input wire logic result_valid,
	input wire logic conv_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// =========
	// helper counters
	logic [4:0] falls_q;
	logic [3:0] idle_q;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) falls_q <= 5'h00;
		else if (frame_sel_n) falls_q <= 5'h00;
		else if ($fell(serial_clk)) falls_q <= falls_q + 5'h01;
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) idle_q <= 4'h0;
		else if (conv_active) idle_q <= 4'h0;
		else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
	end
	// =========
	// checks
	sequence s_start;
		$rose(serial_result_oe);
	endsequence
	a_modes_exclusive: assert property (power_down_en |-> !normal_mode)
		else $error("shutdown and normal flags both high");
	a_oe_in_frame: assert property (serial_result_oe |=> conv_active)
		else $error("output enabled outside a frame");
	a_lead_zeros: assert property (s_start |-> (!serial_result_out)[*8])
		else $error("leading bit not zero");
	a_start_sel_low: assert property (s_start |-> !$past(frame_sel_n, 3))
		else $error("output enabled without select low");
	a_rise_tristate: assert property ($rose(frame_sel_n) |-> ##[1:6] !serial_result_oe)
		else $error("output still driven after select rise");
	a_word_tristate: assert property (falls_q == 5'h10 |-> ##[1:8] !serial_result_oe)
		else $error("output still driven after sixteenth fall");
	a_shdn_at_end: assert property ($rose(power_down_en) |-> idle_q < 4'h6)
		else $error("shutdown entered away from a frame end");
	a_valid_normal: assert property ($rose(result_valid) |-> normal_mode)
		else $error("valid result while not in normal mode");
endmodule // afc_ctrl_asserts
bind afc_ctrl afc_ctrl_asserts i_asserts (.core_clk, .arst_n, .frame_sel_n,
	.serial_clk, .serial_result_out, .serial_result_oe, .power_down_en,
	.normal_mode, .result_valid, .conv_active);

//--- verif/tb_top.sv
// self-checking bench of the frame and power mode controller
`timescale 1ns/100ps
module tb_top;
	import afc_pkg::*;
	logic              core_clk = 1'b0, arst_n = 1'b0, sample_valid = 1'b0;
	logic [DATA_W-1:0] sample_data = 8'h00, exp_d;
	logic              frame_sel_n, serial_clk, sample_ready, sdo, rv, wake;
	logic              serial_result_out, serial_result_oe, power_down_en;
	logic              normal_mode, result_valid, conv_active;
	logic [7:0]        q[$];
	afc_mode_t         mode;
	int fail_count = 0, comparisons = 0, seed = 40152, c, n;
	int tbl[12] = '{16, 16, 1, 2, 1, 9, 11, 16, 10, 16, 16, 15};
	always #10 core_clk = ~core_clk;
	assign sdo = serial_result_oe ? serial_result_out : 1'b1;
	afc_ctrl i_dut (.core_clk, .arst_n, .frame_sel_n, .serial_clk,
		.sample_valid, .sample_ready, .sample_data, .serial_result_out,
		.serial_result_oe, .power_down_en, .normal_mode, .result_valid,
		.conv_active);
	afc_host i_host (.core_clk, .sdo, .frame_sel_n, .serial_clk);
	// =========
	// expectations and reporting
	function automatic afc_mode_t exp_mode(input int c, input afc_mode_t p);
		if (c >= 10) return AFC_MODE_NORMAL;
		if (c >= 2) return AFC_MODE_SHUTDOWN;
		return p;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// =========
	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		#1 arst_n = 1'b1;
		repeat (6) @(posedge core_clk);
		#1 sample_valid = 1'b1;
		sample_data = 8'($random(seed));
		for (n = 0; n < 40 && sample_ready !== 1'b0; n++) begin
			@(posedge core_clk);
			if (sample_ready === 1'b1) q.push_back(sample_data);
			#1 sample_data = 8'($random(seed));
		end
		sample_valid = 1'b0;
		check(16'(q.size()), 16'h0020);
		mode = AFC_MODE_NORMAL;
		wake = 1'b1;
		for (int i = 0; i < 44; i++) begin
			c = (i < 12) ? tbl[i] : $unsigned($random(seed)) % 17;
			exp_d = q.size() ? q.pop_front() : 8'h00;
			fork
				i_host.frame(c);
				begin
					repeat (12) @(posedge core_clk);
					#1 rv = result_valid;
				end
			join
			if (c > 1) check(rv, !wake);
			if (c == 16 && !wake) check(i_host.word[12:5], exp_d);
			check(serial_result_oe, 1'b0);
			check(conv_active, 1'b0);
			mode = exp_mode(c, mode);
			check(power_down_en, mode);
			check(normal_mode, !mode);
			wake = (mode == AFC_MODE_SHUTDOWN) || (wake && c != 16);
		end
		report_and_stop();
	end
endmodule // tb_top
